// ---- hdl/pe_pkg.sv ----
// Package for the priority encoder block: carrier type, timing, encoder.
// Assumes a single 20 MHz clock; all encoder logic is combinational.
package pe_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 20;
    localparam int DEB_PERIOD_US = 1000;
    localparam int DEB_CYCLES = DEB_PERIOD_US * CLK_MHZ;

    // ==========================================================
    // Widths and reset values
    localparam int REQ_W = 8;
    localparam int CODE_W = 3;
    localparam int SER_W = 16;
    localparam int PAR_W = 64;
    localparam int DEC_W = 20;
    localparam logic [3:0] DEB_RST = 4'hF;
    localparam logic [3:0] BCD_EIGHT = 4'h8;
    localparam logic [3:0] BCD_NINE = 4'h9;

    // ==========================================================
    // Carrier of one encoder's outputs, all active low
    typedef struct packed {
        logic chain_enable_out_n;
        logic group_active_n;
        logic [CODE_W-1:0] code_n;
    } pe_enc_t;

    localparam pe_enc_t ENC_IDLE = '{1'b1, 1'b1, 3'h7};

    // ==========================================================
    // Eight-line encoder; ascending scan lets the top line win
    function automatic pe_enc_t pe_encode(input logic enable_in_n,
                                          input logic [REQ_W-1:0] req_n);
        pe_enc_t r;
        r = ENC_IDLE;
        if (!enable_in_n) begin
            r.chain_enable_out_n = 1'b0;
            for (int i = 0; i < REQ_W; i++) begin
                if (!req_n[i]) begin
                    r.code_n = ~i[CODE_W-1:0];
                    r.group_active_n = 1'b0;
                    r.chain_enable_out_n = 1'b1;
                end
            end
        end
        return r;
    endfunction

endpackage

// ---- hdl/pe_top.sv ----
// Priority encoder with series, parallel and decimal variants plus debounce.
// Assumes request inputs are synchronous to clock; only debounce is clocked.
//
// Overview of operation
// RL1: High enable input forces code, group and chain outputs all high.
// RL2: Enabled with no request: code and group high, chain output low.
// RL3: Eight active-low lines encoded to active-low three-bit code; line 7 top.
// RL4: Among simultaneous requests only the highest one is encoded.
// RL5: Any request while enabled: group output low, chain output high.
// RL6: Users must not sample codes while requests or enable are changing.
// RL7: Series cascade: chain output drives next lower encoder's enable.
// RL8: Series low bits combine stage codes; upper bits encode group signals.
// RL9: Parallel: second-level encoder of groups steers low-bit multiplexers.
// RL10: Two levels up to 64 lines, three levels for 65 to 512.
// RL11: Decimal: request 8 or 9 disables base encoder, yields BCD code.
// RL12: Twenty-line BCD: upper group is tens bit and selects units digit.
// RL13: Debounce holds each output bit in a two-deep chain, four chains.
// RL14: Valid rises one clock after two equal captures; stays while equal.
// RL15: Debounce period must be chosen to outlast switch bounce.
// RL16: Reset loads chains with all ones (idle) and clears valid so no false valid follows reset.
module pe_top
    import pe_pkg::*;
#(
    parameter int DEB_DIV = pe_pkg::DEB_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Base encoder
    input wire logic enable_in_n,
    input wire logic [pe_pkg::REQ_W-1:0] request_n,
    output pe_pkg::pe_enc_t enc,
    // Sixteen-line series cascade
    input wire logic [pe_pkg::SER_W-1:0] ser_req_n,
    output logic [3:0] ser_code_n,
    output logic ser_group_n,
    output logic ser_chain_out_n,
    // Sixty-four-line parallel expansion
    input wire logic [pe_pkg::PAR_W-1:0] par_req_n,
    output logic [5:0] par_code_n,
    output logic par_group_n,
    // Decimal encoders, BCD outputs active high
    input wire logic [pe_pkg::DEC_W-1:0] dec_req_n,
    output logic [3:0] dec10_bcd,
    output logic dec10_any,
    output logic dec20_tens,
    output logic [3:0] dec20_bcd,
    // Debounced key code
    output logic [2:0] deb_code_n,
    output logic deb_valid
);
    import pe_pkg::*;

    // ==========================================================
    // Base encoder
    always_comb begin
        enc = pe_encode(enable_in_n, request_n); // RL1 RL2 RL3 RL4 RL5
    end

    // ==========================================================
    // Series cascade; enable ripples, so slowest but smallest
    pe_enc_t ser_hi;
    pe_enc_t ser_lo;
    always_comb begin
        ser_hi = pe_encode(enable_in_n, ser_req_n[15:8]);
        ser_lo = pe_encode(ser_hi.chain_enable_out_n, ser_req_n[7:0]); // RL7
        ser_code_n = {ser_hi.group_active_n,
                      ser_hi.code_n & ser_lo.code_n}; // RL8
        ser_group_n = ser_hi.group_active_n & ser_lo.group_active_n;
        ser_chain_out_n = ser_lo.chain_enable_out_n;
    end

    // ==========================================================
    // Parallel expansion, two levels for 64 lines
    pe_enc_t par_first [REQ_W];
    logic [REQ_W-1:0] par_gs_n;
    pe_enc_t par_second;
    logic [CODE_W-1:0] par_sel;

    for (genvar g = 0; g < REQ_W; g++) begin : g_par
        always_comb begin
            par_first[g] = pe_encode(enable_in_n,
                                     par_req_n[g*REQ_W +: REQ_W]); // RL9
            par_gs_n[g] = par_first[g].group_active_n;
        end
    end

    always_comb begin
        par_second = pe_encode(enable_in_n, par_gs_n); // RL9 RL10
        par_sel = ~par_second.code_n;
        par_code_n = {par_second.code_n, par_first[par_sel].code_n}; // RL9
        par_group_n = par_second.group_active_n;
    end

    // ==========================================================
    // Decimal encoders
    function automatic logic [4:0] pe_dec10(input logic [9:0] d_n);
        pe_enc_t e;
        logic [4:0] r;
        e = pe_encode(~(d_n[8] & d_n[9]), d_n[7:0]); // RL11
        if (!d_n[9]) begin
            r = {1'b1, BCD_NINE};
        end else if (!d_n[8]) begin
            r = {1'b1, BCD_EIGHT};
        end else begin
            r = {~e.group_active_n, 1'b0, ~e.code_n};
        end
        return r;
    endfunction

    logic [4:0] dec_lo;
    logic [4:0] dec_hi;
    always_comb begin
        dec_lo = pe_dec10(dec_req_n[9:0]);
        dec_hi = pe_dec10(dec_req_n[19:10]);
        {dec10_any, dec10_bcd} = dec_lo;
        dec20_tens = dec_hi[4]; // RL12
        dec20_bcd = dec_hi[4] ? dec_hi[3:0] : dec_lo[3:0]; // RL12
    end

    // ==========================================================
    // Debounce divider; period must outlast contact bounce
    localparam int DIV_W = $clog2(DEB_DIV + 1);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic tick;

    always_comb begin
        tick = (div_q == DIV_W'(DEB_DIV - 1)); // RL15
        div_d = tick ? '0 : div_q + 1'b1;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // ==========================================================
    // Debounce chains: bit 3 group, bits 2..0 code, all active low
    logic [3:0] s0_q;
    logic [3:0] s0_d;
    logic [3:0] s1_q;
    logic [3:0] s1_d;
    logic valid_q;
    logic valid_d;

    always_comb begin
        s0_d = s0_q;
        s1_d = s1_q;
        valid_d = valid_q;
        if (tick) begin
            s0_d = {enc.group_active_n, enc.code_n}; // RL13
            s1_d = s0_q; // RL13
            valid_d = (s0_q == s1_q) && !s0_q[3]; // RL14
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s0_q <= DEB_RST; // RL16
            s1_q <= DEB_RST; // RL16
            valid_q <= 1'b0; // RL16
        end else begin
            s0_q <= s0_d;
            s1_q <= s1_d;
            valid_q <= valid_d;
        end
    end

    assign deb_code_n = s1_q[2:0];
    assign deb_valid = valid_q;

    // ==========================================================
    // Checks
    AST_DISABLE: assert property (@(posedge clock) disable iff (!rst_b) // RL1
        enable_in_n |-> enc == ENC_IDLE)
        else $error("disabled encoder outputs not all high");

    AST_IDLE: assert property (@(posedge clock) disable iff (!rst_b) // RL2
        (!enable_in_n && &request_n) |->
        (enc.group_active_n && enc.code_n == 3'h7 && !enc.chain_enable_out_n))
        else $error("idle encoder outputs wrong");

    AST_TOP_WINS: assert property (@(posedge clock) disable iff (!rst_b) // RL4
        (!enable_in_n && !request_n[7]) |-> enc.code_n == 3'h0)
        else $error("line seven not encoded first");

    AST_CODE: assert property (@(posedge clock) disable iff (!rst_b) // RL3
        (!enable_in_n && request_n == 8'hF7) |-> enc.code_n == 3'h4)
        else $error("line three code wrong");

    AST_GROUP: assert property (@(posedge clock) disable iff (!rst_b) // RL5
        (!enable_in_n && !(&request_n)) |->
        (!enc.group_active_n && enc.chain_enable_out_n))
        else $error("group or chain output wrong with request");

    AST_SER_CHAIN: assert property (@(posedge clock) // RL7
        disable iff (!rst_b)
        !ser_hi.group_active_n |-> ser_lo == ENC_IDLE)
        else $error("lower stage not disabled");

    AST_SER_CODE: assert property (@(posedge clock) disable iff (!rst_b) // RL8
        (!enable_in_n && ser_req_n == 16'hFDFF) |-> ser_code_n == 4'h6)
        else $error("series code wrong");

    AST_PAR: assert property (@(posedge clock) disable iff (!rst_b) // RL10
        (!enable_in_n && !par_req_n[63]) |-> par_code_n == 6'h00)
        else $error("parallel top line code wrong");

    AST_DEC: assert property (@(posedge clock) disable iff (!rst_b) // RL11
        !dec_req_n[9] |-> (dec10_bcd == 4'h9 && dec10_any))
        else $error("decimal nine not encoded");

    AST_DEC20: assert property (@(posedge clock) disable iff (!rst_b) // RL12
        (!dec_req_n[18] && &dec_req_n[19]) |->
        (dec20_tens && dec20_bcd == 4'h8))
        else $error("eighteen not encoded");

    AST_DEB_SHIFT: assert property (@(posedge clock) // RL13
        disable iff (!rst_b)
        tick |=> s1_q == $past(s0_q))
        else $error("debounce chain did not shift");

    AST_DEB_VALID: assert property (@(posedge clock) // RL14
        disable iff (!rst_b)
        (tick && s0_q == s1_q && !s0_q[3]) |=> deb_valid ##0 $stable(s1_q))
        else $error("valid not raised after equal captures");

    AST_DEB_DROP: assert property (@(posedge clock) // RL14
        disable iff (!rst_b)
        (tick && s0_q != s1_q) |=> !deb_valid)
        else $error("valid held with unequal captures");

    COV_CASCADE: cover property (@(posedge clock) disable iff (!rst_b)
        !ser_hi.group_active_n && !(&ser_req_n[7:0]));
    COV_PAR_MULTI: cover property (@(posedge clock) disable iff (!rst_b)
        !par_gs_n[7] && !par_gs_n[0]);
    COV_DEC20: cover property (@(posedge clock) disable iff (!rst_b)
        dec20_tens && !dec_req_n[5]);
    COV_DEB: cover property (@(posedge clock) disable iff (!rst_b)
        $rose(deb_valid));

endmodule

// ---- sim/pe_key_model.sv ----
// Key bank model: held request lines plus one bouncing key.
// Assumes its inputs change only at rising clock edges.
module pe_key_model (
    // Clock
    input wire logic clock,
    // Key control
    input wire logic [7:0] held_n,
    input wire logic [2:0] key,
    input wire logic press,
    // Request lines, active low
    output logic [7:0] request_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] bounce_q = 3'h0;
    initial request_n = 8'hFF;
    // =========================================================
    // Contact bounce
    // Six clocks of chatter, well inside the debounce tick pair
    always @(posedge clock) begin
        if (press && bounce_q != 3'h6)
            bounce_q <= bounce_q + 3'h1;
        if (!press)
            bounce_q <= 3'h0;
        request_n <= held_n;
        if (press && (bounce_q[0] || bounce_q == 3'h6))
            request_n[key] <= 1'b0;
    end
endmodule

// ---- sim/tb_pe_top.sv ----
// Testbench for pe_top: encoders, wide variants and key debounce.
// Assumes pe_key_model drives the base request lines.
module tb_pe_top;
    import pe_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic enable_in_n = 1'b1;
    logic [7:0] held_n = 8'hFF;
    logic [2:0] key = 3'h0;
    logic press = 1'b0;
    logic [7:0] request_n;
    logic [15:0] ser_req_n = 16'hFFFF;
    logic [63:0] par_req_n = 64'hFFFFFFFFFFFFFFFF;
    logic [19:0] dec_req_n = 20'hFFFFF;
    pe_enc_t enc;
    logic [3:0] ser_code_n, dec10_bcd, dec20_bcd;
    logic ser_group_n, ser_chain_out_n, par_group_n;
    logic dec10_any, dec20_tens, deb_valid;
    logic [5:0] par_code_n;
    logic [2:0] deb_code_n;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    pe_key_model keys (.clock(clock), .held_n(held_n), .key(key),
        .press(press), .request_n(request_n));
    // Short divider keeps debounce runs brief
    pe_top #(.DEB_DIV(4)) dut (.clock(clock), .rst_b(rst_b),
        .enable_in_n(enable_in_n), .request_n(request_n), .enc(enc),
        .ser_req_n(ser_req_n), .ser_code_n(ser_code_n),
        .ser_group_n(ser_group_n), .ser_chain_out_n(ser_chain_out_n),
        .par_req_n(par_req_n), .par_code_n(par_code_n),
        .par_group_n(par_group_n), .dec_req_n(dec_req_n),
        .dec10_bcd(dec10_bcd), .dec10_any(dec10_any),
        .dec20_tens(dec20_tens), .dec20_bcd(dec20_bcd),
        .deb_code_n(deb_code_n), .deb_valid(deb_valid));

    // =========================================================
    // Clock and watchdog
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            results();
        end
    end

    // =========================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wait_valid(input logic v);
        int n;
        n = 0;
        while (deb_valid !== v && n < 60) begin
            @(posedge clock);
            #10;
            n++;
        end
        #10;
        chk({7'h0, deb_valid}, {7'h0, v});
    endtask

    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =========================================================
    // Scenarios
    task automatic t_base;
        @(posedge clock) held_n <= 8'h00;
        ser_req_n <= 16'h0000;
        par_req_n <= 64'h0;
        repeat (2) @(posedge clock);
        #10 chk({3'h0, enc}, 8'h1F);
        chk({2'h0, ser_code_n, ser_group_n, ser_chain_out_n}, 8'h3F);
        chk({1'b0, par_code_n, par_group_n}, 8'h7F);
        @(posedge clock) enable_in_n <= 1'b0;
        held_n <= 8'hFF;
        ser_req_n <= 16'hFFFF;
        repeat (2) @(posedge clock);
        #10 chk({3'h0, enc}, 8'h0F);
        chk({2'h0, ser_code_n, ser_group_n, ser_chain_out_n}, 8'h3E);
        // Lower lines held too, so only the top one may show
        for (int i = 0; i < 8; i++) begin
            @(posedge clock) held_n <= 8'hFF << (i + 1);
            repeat (2) @(posedge clock);
            #10 chk({3'h0, enc}, {5'h02, 3'(~i)});
        end
        // Single request, so the plain code path is seen alone
        @(posedge clock) held_n <= 8'hF7;
        repeat (2) @(posedge clock);
        #10 chk({3'h0, enc}, 8'h14);
        @(posedge clock) held_n <= 8'hFF;
        $display("test base done");
    endtask

    task automatic t_wide;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock) ser_req_n <= 16'hFFFF << (i + 1);
            #10 chk({2'h0, ser_code_n, ser_group_n, ser_chain_out_n},
                {2'h0, 4'(~i), 2'h1});
        end
        @(posedge clock) ser_req_n <= 16'hFDFF;
        #10 chk({2'h0, ser_code_n, ser_group_n, ser_chain_out_n},
            8'h19);
        for (int i = 0; i < 64; i += 9) begin
            @(posedge clock) par_req_n <= 64'hFFFFFFFFFFFFFFFF << (i + 1);
            #10 chk({1'b0, par_code_n, par_group_n},
                {1'b0, 6'(~i), 1'b0});
        end
        $display("test wide done");
    endtask

    task automatic t_dec;
        for (int i = 0; i < 20; i++) begin
            @(posedge clock) dec_req_n <= 20'hFFFFF << (i + 1);
            #10 if (i < 10) chk({3'h0, dec10_any, dec10_bcd}, 8'(16 + i));
            chk({3'h0, dec20_tens, dec20_bcd}, 8'(i < 10 ? i : i + 6));
        end
        $display("test decimal done");
    endtask

    task automatic t_deb;
        @(posedge clock) key <= 3'h5;
        press <= 1'b1;
        wait_valid(1'b1);
        chk({4'h0, deb_valid, deb_code_n}, 8'h0A);
        @(posedge clock) press <= 1'b0;
        wait_valid(1'b0);
        chk({7'h0, deb_valid}, 8'h00);
        @(posedge clock) press <= 1'b1;
        wait_valid(1'b1);
        @(posedge clock) rst_b <= 1'b0;
        #10 chk({4'h0, deb_valid, deb_code_n}, 8'h07);
        @(posedge clock) rst_b <= 1'b1;
        press <= 1'b0;
        $display("test debounce done");
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        t_base();
        t_wide();
        t_dec();
        t_deb();
        results();
    end
endmodule
